// ### gpio_params.svh
`ifndef GPIO_PARAMS_SVH
`define GPIO_PARAMS_SVH
// Register offsets inside one 16-byte port slot
`define OFF_DATA 4'h0
`define OFF_MODE 4'h4
`define OFF_PULL 4'h8
`define OFF_RTBUF 4'hc
// Port slot numbers (upper address nibble)
`define SLOT_ZERO 4'h0
`define SLOT_MUXED 4'h1
`define SLOT_MIDDLE 4'h2
`define SLOT_UPPER 4'h3
`define SLOT_LOWER 4'h4
`define SLOT_ODRAIN 4'h5
`define SLOT_RT 4'h6
`define SLOT_AIN 4'h7
`define SLOT_CTRL 4'h8
// Control slot: status, mask, real-time control
`define OFF_STAT 4'h0
`define OFF_MASK 4'h4
`define OFF_RTCTL 4'h8
`define BIT_EDGE 0
`define BIT_RT_EN 0
// Reset values
`define RST_MODE 1'b1
`define RST_DATA 1'b0
`define RST_PULL 1'b0
`endif

// ### gpio_types_pkg.sv
`default_nettype none
package gpio_types_pkg;
  typedef enum logic [1:0] {
    PU_NONE = 2'b00,
    PU_PER_PIN = 2'b01,
    PU_GROUP = 2'b11
  } pu_mode_t;
  typedef enum logic {
    BUS_IDLE = 1'b0,
    BUS_ANSWER = 1'b1
  } bus_state_t;
endpackage : gpio_types_pkg
`default_nettype wire

// ### gpio_port_bank.sv
`include "gpio_params.svh"
`default_nettype none
module gpio_port_bank #(
  parameter int WIDTH = 8,
  parameter gpio_types_pkg::pu_mode_t PU_MODE = gpio_types_pkg::PU_PER_PIN,
  parameter bit OPEN_DRAIN = 1'b0
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic data_we,
  input wire logic [WIDTH-1:0] data_wdata,
  input wire logic mode_we,
  input wire logic [WIDTH-1:0] mode_wdata,
  input wire logic pull_we,
  input wire logic [WIDTH-1:0] pull_wdata,
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out,
  output logic [WIDTH-1:0] pin_oe,
  output logic [WIDTH-1:0] pin_pu,
  output logic [WIDTH-1:0] pins_q,
  output logic [WIDTH-1:0] latch_q,
  output logic [WIDTH-1:0] mode_q,
  output logic [WIDTH-1:0] pull_q
);
  logic [WIDTH-1:0] latch_r;
  logic [WIDTH-1:0] mode_r;
  logic [WIDTH-1:0] pull_r;
  logic [WIDTH-1:0] pins_r;
  logic [WIDTH-1:0] pu_nxt;
  logic [WIDTH-1:0] oe_nxt;
  logic [WIDTH-1:0] out_nxt;

  assign pins_q = pins_r;
  assign latch_q = latch_r;
  assign mode_q = mode_r;
  assign pull_q = pull_r;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      latch_r <= {WIDTH{`RST_DATA}};
    else if (ce && data_we)
      latch_r <= data_wdata;
  end

  // One bit per pin, 1 = input
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      mode_r <= {WIDTH{`RST_MODE}};
    else if (ce && mode_we)
      mode_r <= mode_wdata;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n || PU_MODE == gpio_types_pkg::PU_NONE)
      pull_r <= {WIDTH{`RST_PULL}};
    else if (ce && pull_we)
      pull_r <= pull_wdata;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      pins_r <= '0;
    else if (ce)
      pins_r <= pin_in;
  end

  always_comb
  begin
    unique case (PU_MODE)
      gpio_types_pkg::PU_PER_PIN: pu_nxt = pull_r;
      gpio_types_pkg::PU_GROUP: pu_nxt = mode_r & {WIDTH{pull_r[0]}};
      default: pu_nxt = '0;
    endcase
  end

  // Open drain only ever pulls low; a high is left to the board
  assign oe_nxt = OPEN_DRAIN ? (~mode_r & ~latch_r) : ~mode_r;
  assign out_nxt = OPEN_DRAIN ? '0 : latch_r;

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      pin_out <= '0;
      pin_oe <= '0;
      pin_pu <= '0;
    end
    else if (ce)
    begin
      pin_out <= out_nxt;
      pin_oe <= oe_nxt;
      pin_pu <= pu_nxt;
    end
  end
endmodule : gpio_port_bank
`default_nettype wire

// ### rt_output_stage.sv
`default_nettype none
module rt_output_stage #(
  parameter int WIDTH = 8
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic rt_enable,
  input wire logic trigger,
  input wire logic sw_we,
  input wire logic [WIDTH-1:0] sw_wdata,
  output logic load_we,
  output logic [WIDTH-1:0] load_data,
  output logic [WIDTH-1:0] buf_q
);
  logic [WIDTH-1:0] buf_r;

  assign buf_q = buf_r;

  // While owned, software only fills the buffer
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      buf_r <= '0;
    else if (ce && rt_enable && sw_we)
      buf_r <= sw_wdata;
  end

  // A write and a trigger in one cycle load the old buffer contents
  assign load_we = rt_enable ? trigger : sw_we;
  assign load_data = rt_enable ? buf_r : sw_wdata;
endmodule : rt_output_stage
`default_nettype wire

// ### gpio_ports.sv
`include "gpio_params.svh"
`default_nettype none
module gpio_ports (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  input wire logic rt_trigger,
  input wire logic [7:0] analog_shared_input_port_in,
  input wire logic [6:0] port_zero_in,
  output logic [6:0] port_zero_out,
  output logic [6:0] port_zero_oe,
  output logic [6:0] port_zero_pu,
  input wire logic [7:0] muxed_address_data_port_in,
  output logic [7:0] muxed_address_data_port_out,
  output logic [7:0] muxed_address_data_port_oe,
  output logic [7:0] muxed_address_data_port_pu,
  input wire logic [7:0] middle_address_port_in,
  output logic [7:0] middle_address_port_out,
  output logic [7:0] middle_address_port_oe,
  output logic [7:0] middle_address_port_pu,
  input wire logic [7:0] upper_address_strobe_port_in,
  output logic [7:0] upper_address_strobe_port_out,
  output logic [7:0] upper_address_strobe_port_oe,
  output logic [7:0] upper_address_strobe_port_pu,
  input wire logic [7:0] lower_address_port_in,
  output logic [7:0] lower_address_port_out,
  output logic [7:0] lower_address_port_oe,
  output logic [7:0] lower_address_port_pu,
  input wire logic [5:0] open_drain_port_in,
  output logic [5:0] open_drain_port_out,
  output logic [5:0] open_drain_port_oe,
  input wire logic [7:0] realtime_output_port_pins_in,
  output logic [7:0] realtime_output_port_pins_out,
  output logic [7:0] realtime_output_port_pins_oe,
  output logic [7:0] realtime_output_port_pins_pu
);
  gpio_types_pkg::bus_state_t state_r;
  logic [3:0] slot;
  logic [3:0] off;
  logic setup_go;
  logic wr_go;
  logic [7:0] rd_nxt;
  logic err_nxt;
  logic [7:0] p_data;
  logic [7:0] p_mode;
  logic [7:0] p_pull;
  logic [7:0] ain_r;
  logic [7:0] lower_prev_r;
  logic fall;
  logic edge_flag_r;
  logic edge_flag_nxt;
  logic mask_r;
  logic rt_en_r;
  logic rt_load_we;
  logic [7:0] rt_load_data;
  logic [7:0] rt_buf_q;
  logic [6:0] pz_pins, pz_mode, pz_pull;
  logic [7:0] mx_pins, mx_mode, mx_pull;
  logic [7:0] md_pins, md_mode, md_pull;
  logic [7:0] up_pins, up_mode, up_pull;
  logic [7:0] lw_pins, lw_mode, lw_pull;
  logic [5:0] od_pins, od_latch, od_mode;
  logic [7:0] rt_pins, rt_latch, rt_mode, rt_pull;

  function automatic logic at(input logic [3:0] s, input logic [3:0] o,
                              input logic [3:0] ws, input logic [3:0] wo);
    return (s == ws) && (o == wo);
  endfunction : at

  assign slot = paddr[7:4];
  assign off = paddr[3:0];
  assign setup_go = ce && psel && penable &&
                    state_r == gpio_types_pkg::BUS_IDLE;
  // Writes land on the edge that ends the access phase
  assign wr_go = ce && psel && penable && pwrite && pready && !pslverr;

  // Two-cycle answer: decode at the first access edge, pready next cycle
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_r <= gpio_types_pkg::BUS_IDLE;
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end
    else if (ce)
    begin
      unique case (state_r)
        gpio_types_pkg::BUS_IDLE:
        begin
          if (setup_go)
          begin
            state_r <= gpio_types_pkg::BUS_ANSWER;
            pready <= 1'b1;
            pslverr <= err_nxt;
            prdata <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_nxt};
          end
        end
        gpio_types_pkg::BUS_ANSWER:
        begin
          state_r <= gpio_types_pkg::BUS_IDLE;
          pready <= 1'b0;
          pslverr <= 1'b0;
        end
      endcase
    end
  end

  always_comb
  begin
    p_data = 8'h00;
    p_mode = 8'h00;
    p_pull = 8'h00;
    unique case (slot)
      `SLOT_ZERO:
      begin
        p_data = {1'b0, pz_pins};
        p_mode = {1'b0, pz_mode};
        p_pull = {1'b0, pz_pull};
      end
      `SLOT_MUXED:
      begin
        p_data = mx_pins;
        p_mode = mx_mode;
        p_pull = {7'h00, mx_pull[0]};
      end
      `SLOT_MIDDLE:
      begin
        p_data = md_pins;
        p_mode = md_mode;
        p_pull = {7'h00, md_pull[0]};
      end
      `SLOT_UPPER:
      begin
        p_data = up_pins;
        p_mode = up_mode;
        p_pull = {7'h00, up_pull[0]};
      end
      `SLOT_LOWER:
      begin
        p_data = lw_pins;
        p_mode = lw_mode;
        p_pull = lw_pull;
      end
      `SLOT_ODRAIN:
      begin
        p_data = {2'b00, od_pins};
        p_mode = {2'b00, od_mode};
      end
      `SLOT_RT:
      begin
        p_data = rt_pins;
        p_mode = rt_mode;
        p_pull = rt_pull;
      end
      `SLOT_AIN: p_data = ain_r;
      default: p_data = 8'h00;
    endcase
  end

  always_comb
  begin
    err_nxt = 1'b0;
    rd_nxt = 8'h00;
    if (slot == `SLOT_CTRL)
    begin
      unique case (off)
        `OFF_STAT: rd_nxt = {7'h00, edge_flag_r};
        `OFF_MASK: rd_nxt = {7'h00, mask_r};
        `OFF_RTCTL: rd_nxt = {7'h00, rt_en_r};
        default: err_nxt = 1'b1;
      endcase
    end
    else if (slot > `SLOT_CTRL)
      err_nxt = 1'b1;
    else if (off == `OFF_DATA)
      rd_nxt = p_data;
    else if (slot == `SLOT_AIN || slot == `SLOT_ODRAIN && off == `OFF_PULL)
      err_nxt = 1'b1;
    else if (off == `OFF_MODE)
      rd_nxt = p_mode;
    else if (off == `OFF_PULL)
      rd_nxt = p_pull;
    else if (slot == `SLOT_RT && off == `OFF_RTBUF)
      rd_nxt = rt_buf_q;
    else
      err_nxt = 1'b1;
  end

  // Input-only port: sampled, never driven
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      ain_r <= 8'h00;
    else if (ce)
      ain_r <= analog_shared_input_port_in;
  end

  gpio_port_bank #(.WIDTH(7), .PU_MODE(gpio_types_pkg::PU_PER_PIN),
    .OPEN_DRAIN(1'b0)) u_zero (
    .clk(clk), .rst_n(rst_n), .ce(ce),
    .data_we(wr_go && at(slot, off, `SLOT_ZERO, `OFF_DATA)),
    .data_wdata(pwdata[6:0]),
    .mode_we(wr_go && at(slot, off, `SLOT_ZERO, `OFF_MODE)),
    .mode_wdata(pwdata[6:0]),
    .pull_we(wr_go && at(slot, off, `SLOT_ZERO, `OFF_PULL)),
    .pull_wdata(pwdata[6:0]), .pin_in(port_zero_in),
    .pin_out(port_zero_out), .pin_oe(port_zero_oe),
    .pin_pu(port_zero_pu), .pins_q(pz_pins), .latch_q(),
    .mode_q(pz_mode), .pull_q(pz_pull));

  gpio_port_bank #(.WIDTH(8), .PU_MODE(gpio_types_pkg::PU_GROUP),
    .OPEN_DRAIN(1'b0)) u_muxed (
    .clk(clk), .rst_n(rst_n), .ce(ce),
    .data_we(wr_go && at(slot, off, `SLOT_MUXED, `OFF_DATA)),
    .data_wdata(pwdata[7:0]),
    .mode_we(wr_go && at(slot, off, `SLOT_MUXED, `OFF_MODE)),
    .mode_wdata(pwdata[7:0]),
    .pull_we(wr_go && at(slot, off, `SLOT_MUXED, `OFF_PULL)),
    .pull_wdata(pwdata[7:0]), .pin_in(muxed_address_data_port_in),
    .pin_out(muxed_address_data_port_out),
    .pin_oe(muxed_address_data_port_oe),
    .pin_pu(muxed_address_data_port_pu), .pins_q(mx_pins),
    .latch_q(), .mode_q(mx_mode), .pull_q(mx_pull));

  gpio_port_bank #(.WIDTH(8), .PU_MODE(gpio_types_pkg::PU_GROUP),
    .OPEN_DRAIN(1'b0)) u_middle (
    .clk(clk), .rst_n(rst_n), .ce(ce),
    .data_we(wr_go && at(slot, off, `SLOT_MIDDLE, `OFF_DATA)),
    .data_wdata(pwdata[7:0]),
    .mode_we(wr_go && at(slot, off, `SLOT_MIDDLE, `OFF_MODE)),
    .mode_wdata(pwdata[7:0]),
    .pull_we(wr_go && at(slot, off, `SLOT_MIDDLE, `OFF_PULL)),
    .pull_wdata(pwdata[7:0]), .pin_in(middle_address_port_in),
    .pin_out(middle_address_port_out), .pin_oe(middle_address_port_oe),
    .pin_pu(middle_address_port_pu), .pins_q(md_pins),
    .latch_q(), .mode_q(md_mode), .pull_q(md_pull));

  gpio_port_bank #(.WIDTH(8), .PU_MODE(gpio_types_pkg::PU_GROUP),
    .OPEN_DRAIN(1'b0)) u_upper (
    .clk(clk), .rst_n(rst_n), .ce(ce),
    .data_we(wr_go && at(slot, off, `SLOT_UPPER, `OFF_DATA)),
    .data_wdata(pwdata[7:0]),
    .mode_we(wr_go && at(slot, off, `SLOT_UPPER, `OFF_MODE)),
    .mode_wdata(pwdata[7:0]),
    .pull_we(wr_go && at(slot, off, `SLOT_UPPER, `OFF_PULL)),
    .pull_wdata(pwdata[7:0]), .pin_in(upper_address_strobe_port_in),
    .pin_out(upper_address_strobe_port_out),
    .pin_oe(upper_address_strobe_port_oe),
    .pin_pu(upper_address_strobe_port_pu), .pins_q(up_pins),
    .latch_q(), .mode_q(up_mode), .pull_q(up_pull));

  gpio_port_bank #(.WIDTH(8), .PU_MODE(gpio_types_pkg::PU_PER_PIN),
    .OPEN_DRAIN(1'b0)) u_lower (
    .clk(clk), .rst_n(rst_n), .ce(ce),
    .data_we(wr_go && at(slot, off, `SLOT_LOWER, `OFF_DATA)),
    .data_wdata(pwdata[7:0]),
    .mode_we(wr_go && at(slot, off, `SLOT_LOWER, `OFF_MODE)),
    .mode_wdata(pwdata[7:0]),
    .pull_we(wr_go && at(slot, off, `SLOT_LOWER, `OFF_PULL)),
    .pull_wdata(pwdata[7:0]), .pin_in(lower_address_port_in),
    .pin_out(lower_address_port_out), .pin_oe(lower_address_port_oe),
    .pin_pu(lower_address_port_pu), .pins_q(lw_pins),
    .latch_q(), .mode_q(lw_mode), .pull_q(lw_pull));

  gpio_port_bank #(.WIDTH(6), .PU_MODE(gpio_types_pkg::PU_NONE),
    .OPEN_DRAIN(1'b1)) u_odrain (
    .clk(clk), .rst_n(rst_n), .ce(ce),
    .data_we(wr_go && at(slot, off, `SLOT_ODRAIN, `OFF_DATA)),
    .data_wdata(pwdata[5:0]),
    .mode_we(wr_go && at(slot, off, `SLOT_ODRAIN, `OFF_MODE)),
    .mode_wdata(pwdata[5:0]), .pull_we(1'b0), .pull_wdata(6'h00),
    .pin_in(open_drain_port_in), .pin_out(open_drain_port_out),
    .pin_oe(open_drain_port_oe), .pin_pu(),
    .pins_q(od_pins), .latch_q(od_latch), .mode_q(od_mode),
    .pull_q());

  rt_output_stage #(.WIDTH(8)) u_rt_stage (
    .clk(clk), .rst_n(rst_n), .ce(ce), .rt_enable(rt_en_r),
    .trigger(rt_trigger),
    .sw_we(wr_go && at(slot, off, `SLOT_RT, `OFF_DATA)),
    .sw_wdata(pwdata[7:0]), .load_we(rt_load_we),
    .load_data(rt_load_data), .buf_q(rt_buf_q));

  gpio_port_bank #(.WIDTH(8), .PU_MODE(gpio_types_pkg::PU_PER_PIN),
    .OPEN_DRAIN(1'b0)) u_rt (
    .clk(clk), .rst_n(rst_n), .ce(ce),
    .data_we(rt_load_we), .data_wdata(rt_load_data),
    .mode_we(wr_go && at(slot, off, `SLOT_RT, `OFF_MODE)),
    .mode_wdata(pwdata[7:0]),
    .pull_we(wr_go && at(slot, off, `SLOT_RT, `OFF_PULL)),
    .pull_wdata(pwdata[7:0]), .pin_in(realtime_output_port_pins_in),
    .pin_out(realtime_output_port_pins_out),
    .pin_oe(realtime_output_port_pins_oe),
    .pin_pu(realtime_output_port_pins_pu), .pins_q(rt_pins),
    .latch_q(rt_latch), .mode_q(rt_mode), .pull_q(rt_pull));

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      mask_r <= 1'b0;
      rt_en_r <= 1'b0;
    end
    else if (wr_go && at(slot, off, `SLOT_CTRL, `OFF_MASK))
      mask_r <= pwdata[`BIT_EDGE];
    else if (wr_go && at(slot, off, `SLOT_CTRL, `OFF_RTCTL))
      rt_en_r <= pwdata[`BIT_RT_EN];
  end

  // Edge seen on sampled pins, in either direction mode
  assign fall = |(lower_prev_r & ~lw_pins);

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      lower_prev_r <= 8'h00;
    else if (ce)
      lower_prev_r <= lw_pins;
  end

  // A new edge beats a write-one-to-clear in the same cycle
  always_comb
  begin
    edge_flag_nxt = edge_flag_r;
    if (wr_go && at(slot, off, `SLOT_CTRL, `OFF_STAT) && pwdata[`BIT_EDGE])
      edge_flag_nxt = 1'b0;
    if (fall)
      edge_flag_nxt = 1'b1;
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      edge_flag_r <= 1'b0;
      irq <= 1'b0;
    end
    else if (ce)
    begin
      edge_flag_r <= edge_flag_nxt;
      irq <= edge_flag_nxt && mask_r;
    end
  end

  a_dir_per_pin: assert property (
    @(posedge clk) disable iff (!rst_n)
    (wr_go && at(slot, off, `SLOT_ZERO, `OFF_MODE)) ##1 ce
    |=> port_zero_oe == ~$past(pwdata[6:0], 2))
    else $error("Direction write did not reach output enables");

  a_input_only_read: assert property (
    @(posedge clk) disable iff (!rst_n)
    setup_go && !pwrite && at(slot, off, `SLOT_AIN, `OFF_DATA)
    |=> prdata[7:0] == $past(ain_r))
    else $error("Input-only port read returned wrong value");

  a_pullup_per_pin: assert property (
    @(posedge clk) disable iff (!rst_n)
    ce |=> port_zero_pu == $past(pz_pull) &&
    lower_address_port_pu == $past(lw_pull))
    else $error("Per-pin pull-up not following its bit");

  a_group_pullup: assert property (
    @(posedge clk) disable iff (!rst_n)
    (muxed_address_data_port_oe & muxed_address_data_port_pu) == 8'h00 &&
    (middle_address_port_oe & middle_address_port_pu) == 8'h00 &&
    (upper_address_strobe_port_oe & upper_address_strobe_port_pu) == 8'h00)
    else $error("Pull-up on an output pin of an address port");

  a_fall_sets_flag: assert property (
    @(posedge clk) disable iff (!rst_n)
    ce && fall |=> edge_flag_r ##0 (!mask_r || !$past(mask_r) || irq))
    else $error("Falling edge did not set flag");

  a_open_drain: assert property (
    @(posedge clk) disable iff (!rst_n)
    open_drain_port_out == 6'h00 &&
    (open_drain_port_oe & ~$past(~od_mode & ~od_latch)) == 6'h00)
    else $error("Open-drain port drove high or unasked");

  a_rt_trigger_only: assert property (
    @(posedge clk) disable iff (!rst_n)
    rt_en_r && !rt_trigger |=> $stable(rt_latch))
    else $error("Real-time pins changed without trigger");

  a_reset_state: assert property (
    @(posedge clk)
    !rst_n |=> port_zero_oe == 7'h00 && port_zero_pu == 7'h00 &&
    lower_address_port_oe == 8'h00 && muxed_address_data_port_pu == 8'h00 &&
    !edge_flag_r && !irq)
    else $error("Reset state wrong");
endmodule : gpio_ports
`default_nettype wire

// ### pin_board_model.sv
`default_nettype none
module pin_board_model #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic [W-1:0] oe,
  input wire logic [W-1:0] drv,
  input wire logic [W-1:0] pu,
  input wire logic [W-1:0] ext,
  input wire logic [W-1:0] flt,
  output logic [W-1:0] pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [W-1:0] alt_r = '0;
  // Floating pins with no pull wander, so a stale level never reads valid
  always @(posedge clk)
  begin
    alt_r <= ~alt_r;
  end
  assign pin = (oe & drv) | (~oe & flt & (pu | alt_r)) | (~oe & ~flt & ext);
endmodule : pin_board_model
`default_nettype wire

// ### general_purpose_io_ports_tb_top.sv
`include "gpio_params.svh"
`default_nettype none
`define CHK(g, x) begin n_checks++; if ((g) !== (x)) begin n_errors++; \
  $display("ERROR t=%0t got %h exp %h", $time, (g), (x)); end end
module general_purpose_io_ports_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_n, psel, penable, pwrite, rt_trigger, pready, pslverr, irq;
  logic e;
  logic ce;
  logic [7:0] paddr, ain, ext, flt;
  logic [31:0] pwdata, prdata, q;
  logic [6:0] z_in, z_out, z_oe, z_pu;
  logic [7:0] m_in, m_out, m_oe, m_pu, d_in, d_out, d_oe, d_pu;
  logic [7:0] u_in, u_out, u_oe, u_pu, l_in, l_out, l_oe, l_pu;
  logic [7:0] r_in, r_out, r_oe, r_pu;
  logic [5:0] o_in, o_out, o_oe;
  int n_errors = 0;
  int n_checks = 0;
  gpio_ports i_gpio_ports (.clk(clk), .rst_n(rst_n), .ce(ce),
    .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .rt_trigger(rt_trigger), .analog_shared_input_port_in(ain),
    .port_zero_in(z_in), .port_zero_out(z_out), .port_zero_oe(z_oe),
    .port_zero_pu(z_pu), .muxed_address_data_port_in(m_in),
    .muxed_address_data_port_out(m_out), .muxed_address_data_port_oe(m_oe),
    .muxed_address_data_port_pu(m_pu), .middle_address_port_in(d_in),
    .middle_address_port_out(d_out), .middle_address_port_oe(d_oe),
    .middle_address_port_pu(d_pu), .upper_address_strobe_port_in(u_in),
    .upper_address_strobe_port_out(u_out),
    .upper_address_strobe_port_oe(u_oe), .upper_address_strobe_port_pu(u_pu),
    .lower_address_port_in(l_in), .lower_address_port_out(l_out),
    .lower_address_port_oe(l_oe), .lower_address_port_pu(l_pu),
    .open_drain_port_in(o_in), .open_drain_port_out(o_out),
    .open_drain_port_oe(o_oe), .realtime_output_port_pins_in(r_in),
    .realtime_output_port_pins_out(r_out), .realtime_output_port_pins_oe(r_oe),
    .realtime_output_port_pins_pu(r_pu));
  pin_board_model #(.W(7)) i_pin_board_model_z (.clk(clk), .oe(z_oe),
    .drv(z_out), .pu(z_pu), .ext(ext[6:0]), .flt(flt[6:0]), .pin(z_in));
  pin_board_model i_pin_board_model_m (.clk(clk), .oe(m_oe), .drv(m_out),
    .pu(m_pu), .ext(ext), .flt(flt), .pin(m_in));
  pin_board_model i_pin_board_model_d (.clk(clk), .oe(d_oe), .drv(d_out),
    .pu(d_pu), .ext(ext), .flt(flt), .pin(d_in));
  pin_board_model i_pin_board_model_u (.clk(clk), .oe(u_oe), .drv(u_out),
    .pu(u_pu), .ext(ext), .flt(flt), .pin(u_in));
  pin_board_model i_pin_board_model_l (.clk(clk), .oe(l_oe), .drv(l_out),
    .pu(l_pu), .ext(ext), .flt(flt), .pin(l_in));
  pin_board_model i_pin_board_model_r (.clk(clk), .oe(r_oe), .drv(r_out),
    .pu(r_pu), .ext(ext), .flt(flt), .pin(r_in));
  // Open-drain pins only pull low; with no board pull-up, the high level comes from ext
  pin_board_model #(.W(6)) i_pin_board_model_o (.clk(clk), .oe(o_oe),
    .drv(o_out), .pu(6'h0), .ext(ext[5:0]), .flt(flt[5:0]), .pin(o_in));

  function automatic logic [7:0] ad(input int s, input logic [3:0] o);
    return {s[3:0], o};
  endfunction : ad

  function automatic logic [7:0] oe_of(input int s);
    case (s)
      0: return {1'h0, z_oe};
      1: return m_oe;
      2: return d_oe;
      3: return u_oe;
      4: return l_oe;
      default: return r_oe;
    endcase
  endfunction : oe_of

  task automatic end_of_test;
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'h1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'h1;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'h1 && n < 20);
    if (n >= 20)
      n_errors++;
    q = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic x);
    apb(a, 1'h1, d);
    `CHK(e, x);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic x);
    apb(a, 1'h0, 32'h0);
    `CHK(e, x);
    `CHK(q, d);
  endtask : rd

  task automatic st;
    repeat (3) @(posedge clk);
  endtask : st

  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    repeat (5000) @(posedge clk);
    n_errors++;
    end_of_test;
  end

  initial
  begin
    int sl[6] = '{0, 1, 2, 3, 4, 6};
    {rst_n, psel, penable, pwrite, rt_trigger} = 5'h0;
    ce = 1'h1;
    paddr = 8'h0;
    pwdata = 32'h0;
    ain = 8'h3c;
    ext = 8'h00;
    flt = 8'h00;
    repeat (3) @(posedge clk);
    rst_n <= 1'h1;
    `CHK(z_oe | m_oe | d_oe | u_oe | l_oe | r_oe | o_oe, 8'h0);
    `CHK(z_pu | m_pu | d_pu | u_pu | l_pu | r_pu | irq, 8'h0);
    rd(ad(`SLOT_ZERO, `OFF_MODE), 32'h7f, 1'h0);
    rd(ad(`SLOT_CTRL, `OFF_STAT), 32'h0, 1'h0);
    $display("test reset done");
    foreach (sl[i])
    begin
      wr(ad(sl[i], `OFF_MODE), 32'h5a, 1'h0);
      wr(ad(sl[i], `OFF_DATA), 32'hff, 1'h0);
      st;
      `CHK(oe_of(sl[i]), 8'ha5 & (sl[i] == 0 ? 8'h7f : 8'hff));
      rd(ad(sl[i], `OFF_DATA), 32'ha5 & (sl[i] == 0 ? 32'h7f : 32'hff),
        1'h0);
    end
    $display("test direction done");
    for (int s = 1; s <= 3; s++)
      wr(ad(s, `OFF_PULL), 32'h1, 1'h0);
    flt <= 8'hff;
    st;
    `CHK({m_pu, d_pu, u_pu}, 24'h5a5a5a);
    rd(ad(`SLOT_MIDDLE, `OFF_DATA), 32'hff, 1'h0);
    wr(ad(`SLOT_ZERO, `OFF_PULL), 32'h55, 1'h0);
    wr(ad(`SLOT_LOWER, `OFF_PULL), 32'h0f, 1'h0);
    wr(ad(`SLOT_RT, `OFF_PULL), 32'hf0, 1'h0);
    st;
    `CHK({z_pu, l_pu, r_pu}, 23'h550ff0);
    $display("test pull done");
    flt <= 8'h00;
    ext <= 8'hff;
    wr(ad(`SLOT_ODRAIN, `OFF_MODE), 32'h0, 1'h0);
    wr(ad(`SLOT_ODRAIN, `OFF_DATA), 32'h2a, 1'h0);
    st;
    `CHK({o_oe, o_out}, 12'h540);
    rd(ad(`SLOT_ODRAIN, `OFF_DATA), 32'h2a, 1'h0);
    wr(ad(`SLOT_ODRAIN, `OFF_PULL), 32'h1, 1'h1);
    rd(ad(4'h9, 4'h0), 32'h0, 1'h1);
    rd(ad(`SLOT_AIN, `OFF_DATA), 32'h3c, 1'h0);
    ain <= 8'hc3;
    st;
    rd(ad(`SLOT_AIN, `OFF_DATA), 32'hc3, 1'h0);
    wr(ad(`SLOT_AIN, `OFF_MODE), 32'h0, 1'h1);
    $display("test fixed ports done");
    wr(ad(`SLOT_LOWER, `OFF_MODE), 32'hff, 1'h0);
    wr(ad(`SLOT_CTRL, `OFF_MASK), 32'h1, 1'h0);
    wr(ad(`SLOT_CTRL, `OFF_STAT), 32'h1, 1'h0);
    st;
    `CHK(irq, 1'h0);
    ext <= 8'hf7;
    st;
    `CHK(irq, 1'h1);
    rd(ad(`SLOT_CTRL, `OFF_STAT), 32'h1, 1'h0);
    wr(ad(`SLOT_CTRL, `OFF_STAT), 32'h1, 1'h0);
    ext <= 8'hff;
    st;
    `CHK(irq, 1'h0);
    rd(ad(`SLOT_CTRL, `OFF_STAT), 32'h0, 1'h0);
    wr(ad(`SLOT_CTRL, `OFF_MASK), 32'h0, 1'h0);
    ext <= 8'h7f;
    st;
    rd(ad(`SLOT_CTRL, `OFF_STAT), 32'h1, 1'h0);
    `CHK(irq, 1'h0);
    wr(ad(`SLOT_CTRL, `OFF_MASK), 32'h1, 1'h0);
    wr(ad(`SLOT_CTRL, `OFF_STAT), 32'h1, 1'h0);
    st;
    // A frozen block must not take the edge until it runs again
    ce <= 1'h0;
    ext <= 8'h00;
    st;
    `CHK(irq, 1'h0);
    ce <= 1'h1;
    st;
    `CHK(irq, 1'h1);
    $display("test edge done");
    wr(ad(`SLOT_CTRL, `OFF_RTCTL), 32'h1, 1'h0);
    wr(ad(`SLOT_RT, `OFF_MODE), 32'h0, 1'h0);
    wr(ad(`SLOT_RT, `OFF_DATA), 32'h33, 1'h0);
    st;
    `CHK(r_out, 8'hff);
    rd(ad(`SLOT_RT, `OFF_RTBUF), 32'h33, 1'h0);
    rt_trigger <= 1'h1;
    @(posedge clk);
    rt_trigger <= 1'h0;
    st;
    `CHK(r_out, 8'h33);
    $display("test realtime done");
    end_of_test;
  end
endmodule : general_purpose_io_ports_tb_top
`default_nettype wire
